// *** bench/osc_select_monitor.sv ***
// Purpose: Port-level checks of the oscillator select block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
module osc_select_monitor #(
  parameter logic [7:0] SOURCE_RESERVED = 8'h18
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic AWREADY,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic AUTO_TUNE_EN,
  input wire osc_select_pkg::trim_t AUTO_TUNE_TRIM,
  input wire osc_select_pkg::source_t ACTIVE_SOURCE,
  input wire logic SECONDARY_HIGH_POWER,
  input wire osc_select_pkg::trim_t FAST_TRIM,
  input wire osc_select_pkg::rate_t FAST_RATE
);
  import osc_select_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ----
  // Bus handshakes
  // ----
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  rdata_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  wr_excl_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted during response");
  rd_excl_a: assert property (RVALID |-> !ARREADY)
    else $error("read accepted during response");
  // ----
  // Register side effects
  // ----
  power_write_a: assert property ($changed(SECONDARY_HIGH_POWER) |-> $rose(BVALID))
    else $error("power mode changed without a write");
  rate_write_a: assert property ($changed(FAST_RATE) |-> $rose(BVALID) && FAST_RATE <= 4'h8)
    else $error("rate changed illegally");
  trim_follow_a: assert property (AUTO_TUNE_EN |=> FAST_TRIM == $past(AUTO_TUNE_TRIM))
    else $error("trim not following tuner");
  trim_soft_a: assert property ($changed(FAST_TRIM) && !$past(AUTO_TUNE_EN) |-> $rose(BVALID))
    else $error("trim changed without a write");
  active_legal_a: assert property (!SOURCE_RESERVED[ACTIVE_SOURCE])
    else $error("active source is reserved");
endmodule
bind oscillator_select_and_status osc_select_monitor #(.SOURCE_RESERVED(SOURCE_RESERVED)) u_mon (
  .CLK, .RST_B, .AWREADY, .WREADY, .BRESP, .BVALID, .BREADY, .ARREADY, .RDATA, .RVALID,
  .RREADY, .AUTO_TUNE_EN, .AUTO_TUNE_TRIM, .ACTIVE_SOURCE, .SECONDARY_HIGH_POWER,
  .FAST_TRIM, .FAST_RATE
);

// *** bench/test_oscillator_select_and_status.sv ***
// Purpose: Self-checking bench of the oscillator select block
// Assumes: AXI4-Lite master in tasks, 50 ns clock
// Notes:   Byte address is four times the register index
`timescale 1ns/10ps
module test_oscillator_select_and_status;
  import osc_select_pkg::*;
  logic CLK = 1'h0;
  logic RST_B = 1'h0;
  logic [11:0] AWADDR = 12'h000;
  logic [11:0] ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h1;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SECONDARY_HIGH_POWER;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  source_t RESET_SOURCE_CONFIG = 3'h1, ACTIVE_SOURCE;
  divider_t RESET_DIVIDER_CONFIG = 4'h0, ACTIVE_DIVIDER;
  logic SWITCH_PERMIT_CONFIG = 1'h1, AUTO_TUNE_EN = 1'h0, AUTO_TUNE_OUT_OF_RANGE = 1'h0;
  logic [7:0] SOURCE_READY = 8'h02;
  logic [5:0] OSC_ENABLE = 6'h00, OSC_READY = 6'h00;
  trim_t AUTO_TUNE_TRIM = 6'h00, FAST_TRIM;
  rate_t FAST_RATE;
  int fails = 0;
  int n_tests = 0;

  oscillator_select_and_status u_oscillator_select_and_status (
    .CLK, .RST_B, .AWADDR, .AWPROT(3'h0), .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARPROT(3'h0), .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .RESET_SOURCE_CONFIG,
    .RESET_DIVIDER_CONFIG, .SWITCH_PERMIT_CONFIG, .SOURCE_READY, .OSC_ENABLE, .OSC_READY,
    .AUTO_TUNE_EN, .AUTO_TUNE_TRIM, .AUTO_TUNE_OUT_OF_RANGE, .ACTIVE_SOURCE,
    .ACTIVE_DIVIDER, .SECONDARY_HIGH_POWER, .FAST_TRIM, .FAST_RATE, .IRQ
  );

  initial begin
    forever #25 CLK = ~CLK;
  end
  // ----
  // Shared tasks
  // ----
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
    AWADDR <= {i, 2'h0};
    WDATA <= {24'h0, d};
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    @(posedge CLK);
    while (BVALID !== 1'h1) begin
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      @(posedge CLK);
    end
    chk(32'(BRESP), 32'(r));
    BREADY <= 1'h0;
    @(posedge CLK);
  endtask
  task rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] r = 2'h0);
    ARADDR <= {i, 2'h0};
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    @(posedge CLK);
    while (RVALID !== 1'h1) begin
      if (ARREADY) ARVALID <= 1'h0;
      @(posedge CLK);
    end
    chk(RDATA, {24'h0, e});
    chk(32'(RRESP), 32'(r));
    RREADY <= 1'h0;
    @(posedge CLK);
  endtask
  // Polls the active source for at most n cycles
  task wait_src(input source_t s, input int n);
    repeat (n) if (ACTIVE_SOURCE !== s) @(posedge CLK);
    chk(32'(ACTIVE_SOURCE), 32'(s));
  endtask
  task rst();
    RST_B <= 1'h0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'h1;
    @(posedge CLK);
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset();
    rd(10'h0AD, 8'h10);
    rd(10'h0AE, 8'h10);
    rd(10'h0AF, 8'h10);
    rd(10'h0B0, 8'h00);
    rd(10'h0B1, 8'h02);
    rd(10'h0B2, 8'h00);
    rd(10'h0B3, 8'h00, 2'h2);
    wr(10'h0B3, 8'h55, 2'h2);
    wr(10'h0AE, 8'h00);
    rd(10'h0AE, 8'h10);
  endtask
  task t_switch();
    wr(10'h0AD, 8'h21);
    rd(10'h0AF, 8'h00);
    SOURCE_READY <= 8'h06;
    wait_src(3'h2, 6);
    chk(32'(ACTIVE_DIVIDER), 32'h1);
    rd(10'h0AE, 8'h21);
    rd(10'h0AF, 8'h10);
    wr(10'h0AD, 8'h35);
    wr(10'h0AD, 8'h46);
    rd(10'h0AD, 8'h21);
  endtask
  task t_hold();
    wr(10'h0AF, 8'h80);
    wr(10'h0C0, 8'h01);
    wr(10'h0AD, 8'h50);
    SOURCE_READY <= 8'h26;
    repeat (10) @(posedge CLK);
    chk(32'(ACTIVE_SOURCE), 32'h2);
    rd(10'h0AF, 8'h88);
    rd(10'h0C0, 8'h00);
    wr(10'h0AF, 8'h00);
    wait_src(3'h5, 3);
    rd(10'h0AF, 8'h10);
    rd(10'h0C0, 8'h01);
  endtask
  task t_irq();
    chk(32'(IRQ), 32'h0);
    wr(10'h0C1, 8'h01);
    chk(32'(IRQ), 32'h1);
    wr(10'h0C0, 8'h01);
    chk(32'(IRQ), 32'h0);
    rd(10'h0C0, 8'h00);
  endtask
  task t_regs();
    wr(10'h0AF, 8'h40);
    chk(32'(SECONDARY_HIGH_POWER), 32'h1);
    rd(10'h0AF, 8'h50);
    for (int c = 0; c < 10; c++) begin
      wr(10'h0B1, 8'(c));
      rd(10'h0B1, c > 8 ? 8'h08 : 8'(c));
    end
    // A write with the low byte strobe clear must leave the rate alone
    WSTRB <= 4'h0;
    wr(10'h0B1, 8'h03);
    WSTRB <= 4'h1;
    rd(10'h0B1, 8'h08);
    chk(32'(FAST_RATE), 32'h8);
    wr(10'h0B0, 8'h1F);
    chk(32'(FAST_TRIM), 32'h1F);
    wr(10'h0B0, 8'h20);
    rd(10'h0B0, 8'h20);
    AUTO_TUNE_TRIM <= 6'h05;
    AUTO_TUNE_EN <= 1'h1;
    wr(10'h0B0, 8'h11);
    rd(10'h0B0, 8'h05);
    AUTO_TUNE_EN <= 1'h0;
  endtask
  task t_status();
    OSC_ENABLE <= 6'h3F;
    OSC_READY <= 6'h2A;
    repeat (4) @(posedge CLK);
    rd(10'h0B2, 8'hA8);
    OSC_ENABLE <= 6'h0F;
    OSC_READY <= 6'h3F;
    repeat (4) @(posedge CLK);
    rd(10'h0B2, 8'h3C);
    AUTO_TUNE_OUT_OF_RANGE <= 1'h1;
    repeat (3) @(posedge CLK);
    rd(10'h0AC, 8'h02);
    rd(10'h0C0, 8'h02);
    chk(32'(IRQ), 32'h0);
    AUTO_TUNE_OUT_OF_RANGE <= 1'h0;
    repeat (3) @(posedge CLK);
    rd(10'h0AC, 8'h00);
  endtask
  task t_permit();
    SWITCH_PERMIT_CONFIG <= 1'h0;
    RESET_SOURCE_CONFIG <= 3'h6;
    RESET_DIVIDER_CONFIG <= 4'h3;
    rst();
    chk(32'(ACTIVE_SOURCE), 32'h6);
    wr(10'h0AD, 8'h21);
    rd(10'h0AD, 8'h63);
    rd(10'h0C0, 8'h00);
  endtask

  initial begin
    rst();
    t_reset();
    t_switch();
    t_hold();
    t_irq();
    t_regs();
    t_status();
    t_permit();
    conclude();
  end
  initial begin
    #1000000;
    fails++;
    conclude();
  end
endmodule

// *** verilog/osc_select_map.svh ***
// Purpose: Register indices, field positions, reset values and bus codes of the oscillator
//          select and status block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef OSC_SELECT_MAP_SVH
`define OSC_SELECT_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IDX_TUNING_STATUS 10'h0AC
`define IDX_CLOCK_REQUEST_CONTROL 10'h0AD
`define IDX_ACTIVE_CLOCK_REPORT 10'h0AE
`define IDX_CLOCK_SWITCH_CONTROL 10'h0AF
`define IDX_FAST_INTERNAL_TRIM 10'h0B0
`define IDX_FAST_INTERNAL_RATE_SELECT 10'h0B1
`define IDX_OSCILLATOR_READY_REPORT 10'h0B2
`define IDX_EVENT_STATUS 10'h0C0
`define IDX_EVENT_MASK 10'h0C1

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_SOURCE_HI 6
`define POS_SOURCE_LO 4
`define POS_DIVIDER_HI 3
`define POS_DIVIDER_LO 0
`define POS_SWITCH_HOLD 7
`define POS_SECONDARY_POWER 6
`define POS_SWITCH_DONE 4
`define POS_REQUESTED_READY 3
`define POS_TRIM_HI 5
`define POS_RATE_HI 3
`define POS_OUT_OF_RANGE 1
`define POS_READY_HI 7
`define POS_READY_LO 2
`define POS_EV_SWITCH 0
`define POS_EV_RANGE 1

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define RST_TRIM 6'h00
`define RST_RATE 4'h2
`define RST_SWITCH_HOLD 1'b0
`define RST_SECONDARY_POWER 1'b0
`define RST_EVENTS 2'h0
`define RATE_LAST_VALID 4'h8
`define SOURCE_RESERVED_MASK 8'h18
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verilog/osc_select_pkg.sv ***
// Purpose: Types shared by the oscillator select and status block.
// Assumes: Constants live in osc_select_map.svh.
// Notes:   Types only.
package osc_select_pkg;
  typedef logic [2:0] source_t;
  typedef logic [3:0] divider_t;
  typedef logic [5:0] trim_t;
  typedef logic [3:0] rate_t;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_READY} switch_state_e;
endpackage

// *** verilog/oscillator_select_and_status.sv ***
// Purpose: Oscillator source and divider request, switch sequencing, trim, rate select and
//          oscillator ready reporting behind an AXI4-Lite slave.
// Assumes: Tuning engine inputs run on CLK; ready lines come from other clocks.
// Notes:   Byte address of each register is four times its index.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "osc_select_map.svh"

// ----------------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------------
module osc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------------
module oscillator_select_and_status #(
  parameter int ADDR_WIDTH = 12,
  parameter logic [7:0] SOURCE_RESERVED = `SOURCE_RESERVED_MASK
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [ADDR_WIDTH-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_WIDTH-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire osc_select_pkg::source_t RESET_SOURCE_CONFIG,
  input wire osc_select_pkg::divider_t RESET_DIVIDER_CONFIG,
  input wire logic SWITCH_PERMIT_CONFIG,
  input wire logic [7:0] SOURCE_READY,
  input wire logic [5:0] OSC_ENABLE,
  input wire logic [5:0] OSC_READY,
  input wire logic AUTO_TUNE_EN,
  input wire osc_select_pkg::trim_t AUTO_TUNE_TRIM,
  input wire logic AUTO_TUNE_OUT_OF_RANGE,
  output osc_select_pkg::source_t ACTIVE_SOURCE,
  output osc_select_pkg::divider_t ACTIVE_DIVIDER,
  output logic SECONDARY_HIGH_POWER,
  output osc_select_pkg::trim_t FAST_TRIM,
  output osc_select_pkg::rate_t FAST_RATE,
  output logic IRQ
);
  import osc_select_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [ADDR_WIDTH-1:0] waddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic permit_r;
  source_t req_source_r;
  divider_t req_divider_r;
  source_t act_source_r;
  divider_t act_divider_r;
  logic hold_r;
  logic sec_power_r;
  trim_t trim_r;
  rate_t rate_r;
  logic out_of_range_r;
  logic req_ready_r;
  logic [1:0] ev_status_r;
  logic [1:0] ev_mask_r;
  logic irq_r;
  switch_state_e state_r;
  switch_state_e state_nxt;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [7:0] source_ready_s;
  logic [5:0] osc_ready_s;

  osc_sync2 #(.WIDTH(8)) u_sync_source (
    .CLK(CLK),
    .RST_B(RST_B),
    .d(SOURCE_READY),
    .q(source_ready_s)
  );

  osc_sync2 #(.WIDTH(6)) u_sync_osc (
    .CLK(CLK),
    .RST_B(RST_B),
    .d(OSC_READY),
    .q(osc_ready_s)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire [9:0] widx = waddr_r[ADDR_WIDTH-1:2];
  wire [9:0] ridx = ARADDR[ADDR_WIDTH-1:2];
  wire write_fire = !awready_r && !wready_r && !bvalid_r;
  wire write_en = write_fire && wstrb_r;
  wire read_fire = ARVALID && arready_r;

  wire w_request = write_en && (widx == `IDX_CLOCK_REQUEST_CONTROL);
  wire w_switch = write_en && (widx == `IDX_CLOCK_SWITCH_CONTROL);
  wire w_trim = write_en && (widx == `IDX_FAST_INTERNAL_TRIM);
  wire w_rate = write_en && (widx == `IDX_FAST_INTERNAL_RATE_SELECT);
  wire w_status = write_en && (widx == `IDX_EVENT_STATUS);
  wire w_mask = write_en && (widx == `IDX_EVENT_MASK);

  wire w_mapped = (widx == `IDX_TUNING_STATUS) ||
                  (widx == `IDX_CLOCK_REQUEST_CONTROL) ||
                  (widx == `IDX_ACTIVE_CLOCK_REPORT) ||
                  (widx == `IDX_CLOCK_SWITCH_CONTROL) ||
                  (widx == `IDX_FAST_INTERNAL_TRIM) ||
                  (widx == `IDX_FAST_INTERNAL_RATE_SELECT) ||
                  (widx == `IDX_OSCILLATOR_READY_REPORT) ||
                  (widx == `IDX_EVENT_STATUS) ||
                  (widx == `IDX_EVENT_MASK);

  // --------------------------------------------------------------------------
  // Request and switch sequencing
  // --------------------------------------------------------------------------
  wire source_t wr_source = wdata_r[`POS_SOURCE_HI:`POS_SOURCE_LO];
  wire divider_t wr_divider = wdata_r[`POS_DIVIDER_HI:`POS_DIVIDER_LO];
  wire wr_source_reserved = SOURCE_RESERVED[wr_source];
  wire request_load = w_request && permit_r && !wr_source_reserved;
  wire switch_needed = (req_source_r != act_source_r) || (req_divider_r != act_divider_r);
  wire sel_ready = source_ready_s[req_source_r];
  wire switch_done = !switch_needed;
  wire switch_complete = (state_r == SW_READY) && switch_needed && sel_ready && !hold_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SW_IDLE: begin
        if (switch_needed) begin
          state_nxt = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (!switch_needed) begin
          state_nxt = SW_IDLE;
        end else if (sel_ready) begin
          state_nxt = SW_READY;
        end
      end
      SW_READY: begin
        if (!switch_needed || switch_complete) begin
          state_nxt = SW_IDLE;
        end else if (!sel_ready) begin
          state_nxt = SW_WAIT;
        end
      end
      default: begin
        state_nxt = SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_r <= SW_IDLE;
      req_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_ready_r <= (state_nxt == SW_READY);
    end
  end

  // Reset configuration is caught while reset is held
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      permit_r <= SWITCH_PERMIT_CONFIG;
      req_source_r <= RESET_SOURCE_CONFIG;
      req_divider_r <= RESET_DIVIDER_CONFIG;
    end else if (request_load) begin
      req_source_r <= wr_source;
      req_divider_r <= wr_divider;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      act_source_r <= RESET_SOURCE_CONFIG;
      act_divider_r <= RESET_DIVIDER_CONFIG;
    end else if (switch_complete) begin
      act_source_r <= req_source_r;
      act_divider_r <= req_divider_r;
    end
  end

  // --------------------------------------------------------------------------
  // Switch control, trim and rate
  // --------------------------------------------------------------------------
  wire rate_valid = wdata_r[`POS_RATE_HI:0] <= `RATE_LAST_VALID;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      hold_r <= `RST_SWITCH_HOLD;
      sec_power_r <= `RST_SECONDARY_POWER;
    end else if (w_switch) begin
      hold_r <= wdata_r[`POS_SWITCH_HOLD];
      sec_power_r <= wdata_r[`POS_SECONDARY_POWER];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      trim_r <= `RST_TRIM;
    end else if (AUTO_TUNE_EN) begin
      trim_r <= AUTO_TUNE_TRIM;
    end else if (w_trim) begin
      trim_r <= wdata_r[`POS_TRIM_HI:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rate_r <= `RST_RATE;
    end else if (w_rate && rate_valid) begin
      rate_r <= wdata_r[`POS_RATE_HI:0];
    end
  end

  // --------------------------------------------------------------------------
  // Events and interrupt
  // --------------------------------------------------------------------------
  wire range_change = AUTO_TUNE_OUT_OF_RANGE != out_of_range_r;
  wire [1:0] ev_set = {range_change, switch_complete};
  wire [1:0] ev_clr = w_status ? wdata_r[1:0] : 2'h0;
  wire [1:0] ev_nxt = (ev_status_r & ~ev_clr) | ev_set;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      out_of_range_r <= 1'b0;
      ev_status_r <= `RST_EVENTS;
      ev_mask_r <= `RST_EVENTS;
      irq_r <= 1'b0;
    end else begin
      out_of_range_r <= AUTO_TUNE_OUT_OF_RANGE;
      ev_status_r <= ev_nxt;
      if (w_mask) begin
        ev_mask_r <= wdata_r[1:0];
      end
      irq_r <= |(ev_nxt & (w_mask ? wdata_r[1:0] : ev_mask_r));
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  wire [5:0] ready_flags = OSC_ENABLE & osc_ready_s;
  wire [7:0] rd_tuning = {6'h00, out_of_range_r, 1'b0};
  wire [7:0] rd_request = {1'b0, req_source_r, req_divider_r};
  wire [7:0] rd_active = {1'b0, act_source_r, act_divider_r};
  wire [7:0] rd_switch = {hold_r, sec_power_r, 1'b0, switch_done, req_ready_r, 3'h0};
  wire [7:0] rd_trim = {2'h0, trim_r};
  wire [7:0] rd_rate = {4'h0, rate_r};
  wire [7:0] rd_ready = {ready_flags, 2'h0};
  wire [7:0] rd_status = {6'h00, ev_status_r};
  wire [7:0] rd_mask = {6'h00, ev_mask_r};

  wire r_mapped = (ridx == `IDX_TUNING_STATUS) ||
                  (ridx == `IDX_CLOCK_REQUEST_CONTROL) ||
                  (ridx == `IDX_ACTIVE_CLOCK_REPORT) ||
                  (ridx == `IDX_CLOCK_SWITCH_CONTROL) ||
                  (ridx == `IDX_FAST_INTERNAL_TRIM) ||
                  (ridx == `IDX_FAST_INTERNAL_RATE_SELECT) ||
                  (ridx == `IDX_OSCILLATOR_READY_REPORT) ||
                  (ridx == `IDX_EVENT_STATUS) ||
                  (ridx == `IDX_EVENT_MASK);

  wire [7:0] rd_byte =
    (ridx == `IDX_TUNING_STATUS) ? rd_tuning :
    (ridx == `IDX_CLOCK_REQUEST_CONTROL) ? rd_request :
    (ridx == `IDX_ACTIVE_CLOCK_REPORT) ? rd_active :
    (ridx == `IDX_CLOCK_SWITCH_CONTROL) ? rd_switch :
    (ridx == `IDX_FAST_INTERNAL_TRIM) ? rd_trim :
    (ridx == `IDX_FAST_INTERNAL_RATE_SELECT) ? rd_rate :
    (ridx == `IDX_OSCILLATOR_READY_REPORT) ? rd_ready :
    (ridx == `IDX_EVENT_STATUS) ? rd_status :
    (ridx == `IDX_EVENT_MASK) ? rd_mask : 8'h00;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else begin
      if (AWVALID && awready_r) begin
        awready_r <= 1'b0;
        waddr_r <= AWADDR;
      end
      if (WVALID && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= WDATA[7:0];
        wstrb_r <= WSTRB[0];
      end
      if (write_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (read_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= r_mapped ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r <= {24'h000000, rd_byte};
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;
  assign ACTIVE_SOURCE = act_source_r;
  assign ACTIVE_DIVIDER = act_divider_r;
  assign SECONDARY_HIGH_POWER = sec_power_r;
  assign FAST_TRIM = trim_r;
  assign FAST_RATE = rate_r;
  assign IRQ = irq_r;
endmodule
